/* acrb_bank.sv */
// Configuration register bank of a two-core converter, sample clock domain.
// Assumes decoded byte accesses and a calibration engine with a done level.
//
// What this block does
// - Coarse gain bits summed as signed weights
// - Medium, fine codes: 0x80 means zero
// - Trims load self-calibration results after power-up
// - Trims but coarse gain reach converter only while enable set or at calibration done
// - Second core offsets use two's complement
// - Power field: pin, normal, nap, sleep
// - Register power per indexed core, pin global
// - Soft reset keeps power, divider, format A
// - Write 0 then 1 slips clock edge
// - Divider field: pin, one, two, four
// - Format A high field selects output drive
// - Format A low field selects sample coding
// - Format B bit 6 selects DLL range
// - Format B bit 4 enables double rate
// - Calibration flag reads 0 then 1
// - Only calibration flag readable while calibrating
// - Test field selects built-in patterns
// - User code plays pattern words to depth
// - Test selection reaches output after cycles
// - User word is low then high byte
`default_nettype none
`include "acrb_defs.svh"

module acrb_bank #(
   parameter int NUM_CORES  = 2,
   parameter int USER_BYTES = 16
) (
   // Clock and reset
   input  wire logic               CLK,
   input  wire logic               RSTN,
   input  wire logic               SOFT_RESET,
   // Register access
   input  wire acrb_pkg::acrb_req_t REQ,
   output var  logic [7:0]         RDATA,
   output var  logic               RVALID,
   // Calibration engine
   input  wire logic               CAL_DONE,
   input  wire acrb_pkg::acrb_trim_t CAL_TRIM [NUM_CORES],
   // Pins and core index
   input  wire logic [1:0]         TRI_LEVEL_POWER_PIN,
   input  wire logic [1:0]         DIVIDER_SELECT_PIN,
   input  wire logic [NUM_CORES-1:0] CORE_INDEX,
   // Converter controls
   output var  acrb_pkg::acrb_trim_t TRIM_APPLIED [NUM_CORES],
   output var  logic signed [2:0]  COARSE_STEPS [NUM_CORES],
   output var  acrb_pkg::acrb_pwr_t POWER_MODE [NUM_CORES],
   output var  acrb_pkg::acrb_div_t CLOCK_DIVISOR,
   output var  acrb_pkg::acrb_fmt_t FORMAT,
   output var  logic               CLOCK_SLIP,
   // Test pattern output
   output var  logic [15:0]        TEST_WORD,
   output var  logic               TEST_ACTIVE
);

   ////////////////////////////////////////////////////////////////////////////
   // Storage

   acrb_pkg::acrb_trim_t trim_r      [NUM_CORES];
   acrb_pkg::acrb_trim_t cal_saved_r [NUM_CORES];
   acrb_pkg::acrb_pwr_t  pwr_r       [NUM_CORES];
   acrb_pkg::acrb_div_t  div_r;
   logic [7:0]           fmt_a_r;
   logic [7:0]           fmt_b_r;
   logic [7:0]           slip_r;
   logic [7:0]           test_r;
   logic                 adj_en_r;
   logic                 cal_done_r;
   logic                 cal_prev_r;
   logic [7:0]           patt_r      [USER_BYTES];

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   wire       wr        = REQ.wr;
   wire [7:0] addr      = REQ.addr;
   wire [7:0] wd        = REQ.wdata;
   wire       cal_rise  = CAL_DONE & ~cal_prev_r;
   wire       wr_pwr    = wr && addr == `ACRB_OFS_POWER_DOWN_SEL;
   wire       wr_div    = wr && addr == `ACRB_OFS_CLOCK_DIVIDER;
   wire       wr_fmt_a  = wr && addr == `ACRB_OFS_FORMAT_PRIMARY;
   wire       wr_fmt_b  = wr && addr == `ACRB_OFS_FORMAT_SECONDARY;
   wire       wr_slip   = wr && addr == `ACRB_OFS_CLOCK_ADVANCE;
   wire       wr_test   = wr && addr == `ACRB_OFS_TEST_SELECT;
   wire       wr_adj    = wr && addr == `ACRB_OFS_ADJUST_ENABLE;
   wire       wr_patt   = wr && addr >= `ACRB_OFS_USER_FIRST && addr <= `ACRB_OFS_USER_LAST;
   wire [7:0] patt_ofs  = addr - `ACRB_OFS_USER_FIRST;
   wire       pwr_legal = wd[2:0] == 3'h0 || wd[2:0] == 3'h1 || wd[2:0] == 3'h2 ||
                          wd[2:0] == 3'h4;
   wire       div_legal = pwr_legal;
   wire       slip_rise = wr_slip && wd[0] && !slip_r[0];

   // Per-core trim field selects; core n sits at base 0x20 + 6n
   logic [4:0] trim_sel [NUM_CORES];
   always_comb begin
      for (int c = 0; c < NUM_CORES; c++) begin
         for (int f = 0; f < 5; f++) begin
            trim_sel[c][4-f] = wr && addr == 8'(8'h20 + 8'(6 * c) + 8'(f));
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Calibration capture and trim registers

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         cal_done_r <= 1'b0;
         cal_prev_r <= 1'b0;
      end else begin
         cal_prev_r <= CAL_DONE;
         if (cal_rise) begin
            cal_done_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         for (int c = 0; c < NUM_CORES; c++) begin
            trim_r[c]      <= '{`ACRB_RST_TRIM_ZERO, `ACRB_RST_TRIM_ZERO,
                                `ACRB_RST_TRIM_ZERO, `ACRB_RST_TRIM_MID, `ACRB_RST_TRIM_MID};
            cal_saved_r[c] <= '{`ACRB_RST_TRIM_ZERO, `ACRB_RST_TRIM_ZERO,
                                `ACRB_RST_TRIM_ZERO, `ACRB_RST_TRIM_MID, `ACRB_RST_TRIM_MID};
         end
      end else begin
         for (int c = 0; c < NUM_CORES; c++) begin
            if (cal_rise) begin
               trim_r[c]      <= CAL_TRIM[c];
               cal_saved_r[c] <= CAL_TRIM[c];
            end else if (SOFT_RESET) begin
               trim_r[c] <= cal_saved_r[c];
            end else begin
               if (trim_sel[c][4]) trim_r[c].off_coarse  <= wd;
               if (trim_sel[c][3]) trim_r[c].off_fine    <= wd;
               if (trim_sel[c][2]) trim_r[c].gain_coarse <= {4'h0, wd[3:0]};
               if (trim_sel[c][1]) trim_r[c].gain_medium <= wd;
               if (trim_sel[c][0]) trim_r[c].gain_fine   <= wd;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers

   // Power, divider and format A survive a soft reset
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         for (int c = 0; c < NUM_CORES; c++) begin
            pwr_r[c] <= acrb_pkg::ACRB_PWR_PIN;
         end
         div_r   <= acrb_pkg::ACRB_DIV_PIN;
         fmt_a_r <= `ACRB_RST_REG;
      end else begin
         for (int c = 0; c < NUM_CORES; c++) begin
            if (wr_pwr && pwr_legal && CORE_INDEX[c]) begin
               pwr_r[c] <= acrb_pkg::acrb_pwr_t'(wd[2:0]);
            end
         end
         if (wr_div && div_legal) begin
            div_r <= acrb_pkg::acrb_div_t'(wd[2:0]);
         end
         if (wr_fmt_a) begin
            fmt_a_r <= wd;
         end
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         fmt_b_r  <= `ACRB_RST_REG;
         slip_r   <= `ACRB_RST_REG;
         test_r   <= `ACRB_RST_REG;
         adj_en_r <= 1'b0;
      end else if (SOFT_RESET) begin
         fmt_b_r  <= `ACRB_RST_REG;
         slip_r   <= `ACRB_RST_REG;
         test_r   <= `ACRB_RST_REG;
         adj_en_r <= 1'b0;
      end else begin
         if (wr_fmt_b) fmt_b_r <= wd;
         if (wr_slip)  slip_r  <= wd;
         if (wr_test)  test_r  <= wd;
         if (wr_adj)   adj_en_r <= wd[0];
      end
   end

   // Pattern bytes survive a soft reset
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         for (int i = 0; i < USER_BYTES; i++) begin
            patt_r[i] <= `ACRB_RST_REG;
         end
      end else if (wr_patt) begin
         patt_r[patt_ofs[3:0]] <= wd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path

   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      case (addr)
         `ACRB_OFS_CORE0_OFF_COARSE: rd_mux = trim_r[0].off_coarse;
         `ACRB_OFS_CORE0_OFF_FINE:   rd_mux = trim_r[0].off_fine;
         `ACRB_OFS_CORE0_GAIN_CRS:   rd_mux = trim_r[0].gain_coarse;
         `ACRB_OFS_CORE0_GAIN_MED:   rd_mux = trim_r[0].gain_medium;
         `ACRB_OFS_CORE0_GAIN_FINE:  rd_mux = trim_r[0].gain_fine;
         `ACRB_OFS_POWER_DOWN_SEL:   rd_mux = {5'h00, (CORE_INDEX[0] ? pwr_r[0] : pwr_r[1])};
         `ACRB_OFS_CORE1_OFF_COARSE: rd_mux = trim_r[1].off_coarse;
         `ACRB_OFS_CORE1_OFF_FINE:   rd_mux = trim_r[1].off_fine;
         `ACRB_OFS_CORE1_GAIN_CRS:   rd_mux = trim_r[1].gain_coarse;
         `ACRB_OFS_CORE1_GAIN_MED:   rd_mux = trim_r[1].gain_medium;
         `ACRB_OFS_CORE1_GAIN_FINE:  rd_mux = trim_r[1].gain_fine;
         `ACRB_OFS_CLOCK_ADVANCE:    rd_mux = slip_r;
         `ACRB_OFS_CLOCK_DIVIDER:    rd_mux = {5'h00, div_r};
         `ACRB_OFS_FORMAT_PRIMARY:   rd_mux = fmt_a_r;
         `ACRB_OFS_FORMAT_SECONDARY: rd_mux = fmt_b_r;
         `ACRB_OFS_TEST_SELECT:      rd_mux = test_r;
         `ACRB_OFS_ADJUST_ENABLE:    rd_mux = {7'h00, adj_en_r};
         default: begin
            if (addr >= `ACRB_OFS_USER_FIRST && addr <= `ACRB_OFS_USER_LAST) begin
               rd_mux = patt_r[patt_ofs[3:0]];
            end
         end
      endcase
   end

   // Only the flag reads before calibration ends
   wire       rd_is_flag = addr == `ACRB_OFS_CAL_DONE_FLAG;
   wire [7:0] rdata_nxt  = rd_is_flag ? {7'h00, cal_done_r} :
                           (cal_done_r ? rd_mux : 8'h00);

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         RDATA  <= 8'h00;
         RVALID <= 1'b0;
      end else begin
         RVALID <= REQ.rd;
         if (REQ.rd) RDATA <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Converter controls

   // Pin decode: 00 normal, 01 nap, 10 sleep
   wire acrb_pkg::acrb_pwr_t pin_pwr =
      TRI_LEVEL_POWER_PIN == 2'h1 ? acrb_pkg::ACRB_PWR_NAP :
      TRI_LEVEL_POWER_PIN == 2'h2 ? acrb_pkg::ACRB_PWR_SLEEP : acrb_pkg::ACRB_PWR_NORMAL;
   wire acrb_pkg::acrb_div_t pin_div =
      DIVIDER_SELECT_PIN == 2'h1 ? acrb_pkg::ACRB_DIV_2 :
      DIVIDER_SELECT_PIN == 2'h2 ? acrb_pkg::ACRB_DIV_4 : acrb_pkg::ACRB_DIV_1;

   // Coarse sum in 1.4% units: +2, +1, -2, -1
   function automatic logic signed [2:0] coarse_sum(input logic [3:0] b);
      logic signed [3:0] s;
      s = 4'sh0;
      if (b[3]) s = s + 4'sh2;
      if (b[2]) s = s + 4'sh1;
      if (b[1]) s = s - 4'sh2;
      if (b[0]) s = s - 4'sh1;
      return s[2:0];
   endfunction

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         for (int c = 0; c < NUM_CORES; c++) begin
            TRIM_APPLIED[c] <= '{`ACRB_RST_TRIM_ZERO, `ACRB_RST_TRIM_ZERO,
                                 `ACRB_RST_TRIM_ZERO, `ACRB_RST_TRIM_MID, `ACRB_RST_TRIM_MID};
            COARSE_STEPS[c] <= 3'sh0;
            POWER_MODE[c]   <= acrb_pkg::ACRB_PWR_NORMAL;
         end
         CLOCK_DIVISOR <= acrb_pkg::ACRB_DIV_1;
         FORMAT        <= '0;
         CLOCK_SLIP    <= 1'b0;
      end else begin
         for (int c = 0; c < NUM_CORES; c++) begin
            TRIM_APPLIED[c].gain_coarse <= trim_r[c].gain_coarse;
            COARSE_STEPS[c] <= coarse_sum(trim_r[c].gain_coarse[3:0]);
            if (adj_en_r || cal_rise) begin
               TRIM_APPLIED[c].off_coarse  <= cal_rise ? CAL_TRIM[c].off_coarse
                                                       : trim_r[c].off_coarse;
               TRIM_APPLIED[c].off_fine    <= cal_rise ? CAL_TRIM[c].off_fine
                                                       : trim_r[c].off_fine;
               TRIM_APPLIED[c].gain_medium <= cal_rise ? CAL_TRIM[c].gain_medium
                                                       : trim_r[c].gain_medium;
               TRIM_APPLIED[c].gain_fine   <= cal_rise ? CAL_TRIM[c].gain_fine
                                                       : trim_r[c].gain_fine;
            end
            POWER_MODE[c] <= pwr_r[c] == acrb_pkg::ACRB_PWR_PIN ? pin_pwr : pwr_r[c];
         end
         CLOCK_DIVISOR <= div_r == acrb_pkg::ACRB_DIV_PIN ? pin_div : div_r;
         FORMAT.phy      <= fmt_a_r[`ACRB_FMT_PHY_MSB:`ACRB_FMT_PHY_LSB];
         FORMAT.coding   <= fmt_a_r[`ACRB_FMT_CODE_MSB:`ACRB_FMT_CODE_LSB];
         FORMAT.dll_slow <= fmt_b_r[`ACRB_FMTB_DLL_BIT];
         FORMAT.ddr      <= fmt_b_r[`ACRB_FMTB_DDR_BIT];
         CLOCK_SLIP      <= slip_rise;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Test pattern generator

   // Selection is retimed so a half-written selection never shows
   logic [7:0] test_meta_r;
   logic [7:0] test_sync_r;
   logic [15:0] ramp_r;
   logic        alt_r;
   logic [2:0]  uidx_r;

   wire [3:0] tmode = test_sync_r[`ACRB_TEST_MODE_MSB:`ACRB_TEST_MODE_LSB];
   wire [2:0] depth = test_sync_r[`ACRB_TEST_DEPTH_MSB:`ACRB_TEST_DEPTH_LSB];
   wire [3:0] ulo   = {uidx_r, 1'b0};
   wire [3:0] uhi   = {uidx_r, 1'b1};
   wire [15:0] user_word = {patt_r[uhi], patt_r[ulo]};
   wire [15:0] alt_word  = alt_r ? `ACRB_WORD_ALT_A : `ACRB_WORD_ALT_B;
   wire [15:0] rail_word = alt_r ? `ACRB_WORD_ONES : `ACRB_WORD_ZERO;

   logic [15:0] word_nxt;
   logic        active_nxt;
   always_comb begin
      word_nxt   = `ACRB_WORD_ZERO;
      active_nxt = 1'b1;
      case (tmode)
         `ACRB_TST_MID:    word_nxt = `ACRB_WORD_MID;
         `ACRB_TST_POS:    word_nxt = `ACRB_WORD_ONES;
         `ACRB_TST_NEG:    word_nxt = `ACRB_WORD_ZERO;
         `ACRB_TST_RAMP:   word_nxt = ramp_r;
         `ACRB_TST_RATE_A: word_nxt = FORMAT.ddr ? alt_word : rail_word;
         `ACRB_TST_RATE_B: word_nxt = FORMAT.ddr ? rail_word : alt_word;
         `ACRB_TST_USER:   word_nxt = user_word;
         default:          active_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         test_meta_r <= 8'h00;
         test_sync_r <= 8'h00;
         ramp_r      <= 16'h0000;
         alt_r       <= 1'b0;
         uidx_r      <= 3'h0;
         TEST_WORD   <= 16'h0000;
         TEST_ACTIVE <= 1'b0;
      end else begin
         test_meta_r <= test_r;
         test_sync_r <= test_meta_r;
         ramp_r      <= tmode == `ACRB_TST_RAMP ? ramp_r + 16'h0001 : 16'h0000;
         alt_r       <= active_nxt ? ~alt_r : 1'b0;
         if (tmode != `ACRB_TST_USER || uidx_r == depth) begin
            uidx_r <= 3'h0;
         end else begin
            uidx_r <= uidx_r + 3'h1;
         end
         TEST_WORD   <= word_nxt;
         TEST_ACTIVE <= active_nxt;
      end
   end

endmodule

`default_nettype wire

/* acrb_defs.svh */
// Constants of the converter configuration register bank.
// Assumes inclusion by bare name from the package and the bank module.
`ifndef ACRB_DEFS_SVH
`define ACRB_DEFS_SVH

// Register offsets
`define ACRB_OFS_CORE0_OFF_COARSE 8'h20
`define ACRB_OFS_CORE0_OFF_FINE   8'h21
`define ACRB_OFS_CORE0_GAIN_CRS   8'h22
`define ACRB_OFS_CORE0_GAIN_MED   8'h23
`define ACRB_OFS_CORE0_GAIN_FINE  8'h24
`define ACRB_OFS_POWER_DOWN_SEL   8'h25
`define ACRB_OFS_CORE1_OFF_COARSE 8'h26
`define ACRB_OFS_CORE1_OFF_FINE   8'h27
`define ACRB_OFS_CORE1_GAIN_CRS   8'h28
`define ACRB_OFS_CORE1_GAIN_MED   8'h29
`define ACRB_OFS_CORE1_GAIN_FINE  8'h2A
`define ACRB_OFS_CLOCK_ADVANCE    8'h71
`define ACRB_OFS_CLOCK_DIVIDER    8'h72
`define ACRB_OFS_FORMAT_PRIMARY   8'h73
`define ACRB_OFS_FORMAT_SECONDARY 8'h74
`define ACRB_OFS_CAL_DONE_FLAG    8'hB6
`define ACRB_OFS_TEST_SELECT      8'hC0
`define ACRB_OFS_USER_FIRST       8'hC1
`define ACRB_OFS_USER_LAST        8'hD0
`define ACRB_OFS_ADJUST_ENABLE    8'hFE

// Field positions
`define ACRB_FMT_PHY_MSB   7
`define ACRB_FMT_PHY_LSB   5
`define ACRB_FMT_CODE_MSB  2
`define ACRB_FMT_CODE_LSB  0
`define ACRB_FMTB_DLL_BIT  6
`define ACRB_FMTB_DDR_BIT  4
`define ACRB_TEST_MODE_MSB 7
`define ACRB_TEST_MODE_LSB 4
`define ACRB_TEST_DEPTH_MSB 2
`define ACRB_TEST_DEPTH_LSB 0

// Reset values
`define ACRB_RST_TRIM_ZERO 8'h00
`define ACRB_RST_TRIM_MID  8'h80
`define ACRB_RST_REG       8'h00

// Test pattern codes and words
`define ACRB_TST_OFF       4'h0
`define ACRB_TST_MID       4'h1
`define ACRB_TST_POS       4'h2
`define ACRB_TST_NEG       4'h3
`define ACRB_TST_RATE_A    4'h4
`define ACRB_TST_RATE_B    4'h7
`define ACRB_TST_USER      4'h8
`define ACRB_TST_RAMP      4'hA
`define ACRB_WORD_MID      16'h8000
`define ACRB_WORD_ONES     16'hFFFF
`define ACRB_WORD_ZERO     16'h0000
`define ACRB_WORD_ALT_A    16'hAAAA
`define ACRB_WORD_ALT_B    16'h5555

`endif

/* acrb_pkg.sv */
// Types of the converter configuration register bank.
// Assumes acrb_defs.svh is on the include path.
`default_nettype none
`include "acrb_defs.svh"

package acrb_pkg;

   // Trim set of one converter core
   typedef struct packed {
      logic [7:0] off_coarse;
      logic [7:0] off_fine;
      logic [7:0] gain_coarse;
      logic [7:0] gain_medium;
      logic [7:0] gain_fine;
   } acrb_trim_t;

   // Power mode, one-hot apart from pin control
   typedef enum logic [2:0] {
      ACRB_PWR_PIN    = 3'h0,
      ACRB_PWR_NORMAL = 3'h1,
      ACRB_PWR_NAP    = 3'h2,
      ACRB_PWR_SLEEP  = 3'h4
   } acrb_pwr_t;

   // Sample clock divisor
   typedef enum logic [2:0] {
      ACRB_DIV_PIN = 3'h0,
      ACRB_DIV_1   = 3'h1,
      ACRB_DIV_2   = 3'h2,
      ACRB_DIV_4   = 3'h4
   } acrb_div_t;

   // Output format controls
   typedef struct packed {
      logic [2:0] phy;
      logic [2:0] coding;
      logic       dll_slow;
      logic       ddr;
   } acrb_fmt_t;

   // Register access request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } acrb_req_t;

endpackage

`default_nettype wire

/* acrb_bank_asserts.sv */
// Concurrent checks of the configuration register bank, bound to its ports.
// Assumes acrb_pkg is compiled first and one clock domain on CLK.
`default_nettype none

module acrb_bank_chk #(
   parameter int NUM_CORES = 2
) (
   // Clock and reset
   input wire logic                   CLK,
   input wire logic                   RSTN,
   input wire logic                   SOFT_RESET,
   // Register access and calibration
   input wire acrb_pkg::acrb_req_t    REQ,
   input wire logic [7:0]             RDATA,
   input wire logic                   CAL_DONE,
   input wire logic [NUM_CORES-1:0]   CORE_INDEX,
   // Converter controls
   input wire logic signed [2:0]      COARSE_STEPS [NUM_CORES],
   input wire acrb_pkg::acrb_pwr_t    POWER_MODE [NUM_CORES],
   input wire acrb_pkg::acrb_div_t    CLOCK_DIVISOR,
   input wire acrb_pkg::acrb_fmt_t    FORMAT,
   input wire logic                   CLOCK_SLIP,
   input wire logic [15:0]            TEST_WORD,
   input wire logic                   TEST_ACTIVE
);
   logic cal_seen_r;

   function automatic logic signed [2:0] wgt(input logic [3:0] d);
      int w;
      w = 2 * d[3] + d[2] - 2 * d[1] - d[0];
      return 3'(w);
   endfunction

   // Mirror of the calibration flag
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) cal_seen_r <= 1'b0;
      else cal_seen_r <= cal_seen_r | CAL_DONE;
   end

   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);

   ////////////////////////////////////////////////////////////////////////////
   a_coarse_sum: assert property (
      REQ.wr && REQ.addr == 8'h22 && CAL_DONE && $past(CAL_DONE) && !SOFT_RESET
      |-> ##2 COARSE_STEPS[0] == wgt($past(REQ.wdata[3:0], 2)))
      else $error("coarse gain sum wrong");
   a_early_read_zero: assert property (
      REQ.rd && REQ.addr != 8'hB6 && !cal_seen_r |=> RDATA == 8'h00)
      else $error("read before calibration not zero");
   a_cal_flag_read: assert property (
      REQ.rd && REQ.addr == 8'hB6 |=> RDATA[0] == $past(cal_seen_r))
      else $error("calibration flag wrong");
   a_power_indexed: assert property (
      REQ.wr && REQ.addr == 8'h25 && CORE_INDEX[0] && REQ.wdata[2:0] inside {3'h1, 3'h2, 3'h4}
      |-> ##2 POWER_MODE[0] == $past(REQ.wdata[2:0], 2))
      else $error("power mode not applied");
   a_divider_set: assert property (
      REQ.wr && REQ.addr == 8'h72 && REQ.wdata[2:0] inside {3'h1, 3'h2, 3'h4}
      |-> ##2 CLOCK_DIVISOR == $past(REQ.wdata[2:0], 2))
      else $error("divider not applied");
   a_format_set: assert property (
      REQ.wr && REQ.addr == 8'h73 |-> ##2 FORMAT.phy == $past(REQ.wdata[7:5], 2)
      && FORMAT.coding == $past(REQ.wdata[2:0], 2))
      else $error("format A not applied");
   a_format_b_set: assert property (
      REQ.wr && REQ.addr == 8'h74 && !SOFT_RESET |-> ##2 FORMAT.ddr == $past(REQ.wdata[4], 2)
      && FORMAT.dll_slow == $past(REQ.wdata[6], 2))
      else $error("format B not applied");
   a_slip_single: assert property (
      CLOCK_SLIP |=> !CLOCK_SLIP)
      else $error("slip longer than one cycle");
   a_slip_cause: assert property (
      CLOCK_SLIP |-> $past(REQ.wr && REQ.addr == 8'h71 && REQ.wdata[0]))
      else $error("slip without write of one");
   a_test_midscale: assert property (
      REQ.wr && REQ.addr == 8'hC0 && REQ.wdata[7:4] == 4'h1 && !SOFT_RESET
      |-> ##4 TEST_WORD == 16'h8000 && TEST_ACTIVE)
      else $error("midscale pattern missing");
endmodule

bind acrb_bank acrb_bank_chk #(.NUM_CORES(NUM_CORES)) u_acrb_bank_chk (
   .CLK, .RSTN, .SOFT_RESET, .REQ, .RDATA, .CAL_DONE, .CORE_INDEX, .COARSE_STEPS,
   .POWER_MODE, .CLOCK_DIVISOR, .FORMAT, .CLOCK_SLIP, .TEST_WORD, .TEST_ACTIVE);

`default_nettype wire

/* acrb_host.sv */
// Host model issuing byte accesses as the serial front end would.
// Assumes the bank samples requests on the rising edge of clk.
`default_nettype none

module acrb_host (
   // Clock
   input  wire logic              clk,
   // Access request and answer
   output var acrb_pkg::acrb_req_t req,
   input  wire logic [7:0]        rdata,
   input  wire logic              rvalid
);
   timeunit 1ns;
   timeprecision 1ns;

   initial req = '0;

   // One rising edge per request, one idle cycle after
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk);
      req = '0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(negedge clk);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clk);
      req = '0;
      v = rvalid;
      d = rdata;
   endtask

   // A stored zero must precede the one
   task automatic slip();
      wr(8'h71, 8'h00);
      wr(8'h71, 8'h01);
   endtask
endmodule

`default_nettype wire

/* acrb_bank_bench.sv */
// Self-checking bench of the configuration register bank.
// Assumes the bank, its checker and the host model are compiled before.
`default_nettype none

module acrb_bank_bench;
   timeunit 1ns;
   timeprecision 1ns;

   logic                 clk, rstn, soft_reset, cal_done, rvalid, clock_slip, test_active;
   logic [1:0]           pwr_pin, div_pin, core_index;
   logic [7:0]           rdata;
   logic [15:0]          test_word;
   acrb_pkg::acrb_req_t  req;
   acrb_pkg::acrb_trim_t cal_trim [2];
   acrb_pkg::acrb_trim_t trim_applied [2];
   logic signed [2:0]    coarse_steps [2];
   acrb_pkg::acrb_pwr_t  power_mode [2];
   acrb_pkg::acrb_div_t  clock_divisor;
   acrb_pkg::acrb_fmt_t  format;
   int                   err_total = 0, samples_checked = 0, cycles = 0, slips = 0;

   acrb_bank u_acrb_bank (.CLK(clk), .RSTN(rstn), .SOFT_RESET(soft_reset), .REQ(req),
      .RDATA(rdata), .RVALID(rvalid), .CAL_DONE(cal_done), .CAL_TRIM(cal_trim),
      .TRI_LEVEL_POWER_PIN(pwr_pin), .DIVIDER_SELECT_PIN(div_pin), .CORE_INDEX(core_index),
      .TRIM_APPLIED(trim_applied), .COARSE_STEPS(coarse_steps), .POWER_MODE(power_mode),
      .CLOCK_DIVISOR(clock_divisor), .FORMAT(format), .CLOCK_SLIP(clock_slip),
      .TEST_WORD(test_word), .TEST_ACTIVE(test_active));
   acrb_host u_acrb_host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

   ////////////////////////////////////////////////////////////////////////////
   task automatic results();
      if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       v;
      u_acrb_host.rd(a, d, v);
      chk(16'(d), 16'(exp));
      chk(16'(v), 16'h1);
   endtask

   task automatic t_cal();
      rdc(8'hB6, 8'h00);
      rdc(8'h23, 8'h00);
      cal_done = 1'b1;
      wt(2);
      rdc(8'hB6, 8'h01);
      rdc(8'h23, 8'h91);
      rdc(8'h50, 8'h00);
      chk(16'(trim_applied[1].gain_medium), 16'h00A5);
      chk(16'(coarse_steps[1]), 16'hFFFD);
   endtask

   task automatic w(input logic [7:0] a, input logic [7:0] d);
      u_acrb_host.wr(a, d);
   endtask

   task automatic t_trim();
      w(8'hFE, 8'h00);
      w(8'h23, 8'h40);
      wt(3);
      chk(16'(trim_applied[0].gain_medium), 16'h91);
      w(8'hFE, 8'h01);
      wt(2);
      chk(16'(trim_applied[0].gain_medium), 16'h40);
      w(8'h27, 8'hF6);
      wt(2);
      chk(16'(trim_applied[1].off_fine), 16'hF6);
      rdc(8'h27, 8'hF6);
      w(8'hFE, 8'h00);
   endtask

   task automatic t_coarse();
      logic [3:0]  code [4] = '{4'h3, 4'hC, 4'h5, 4'h8};
      logic [15:0] exp [4] = '{16'hFFFD, 16'h3, 16'h0, 16'h2};
      for (int i = 0; i < 4; i++) begin
         w(8'h22, {4'h0, code[i]});
         wt(2);
         chk(16'(coarse_steps[0]), exp[i]);
      end
   endtask

   task automatic t_modes();
      logic [7:0] code [3] = '{8'h01, 8'h02, 8'h04};
      for (int i = 0; i < 3; i++) begin
         w(8'h25, code[i]);
         w(8'h72, code[i]);
         wt(2);
         chk(16'(power_mode[0]), 16'(code[i]));
         chk(16'(power_mode[1]), 16'h1);
         chk(16'(clock_divisor), 16'(code[i]));
      end
      w(8'h25, 8'h03);
      w(8'h72, 8'h07);
      wt(2);
      chk(16'(power_mode[0]), 16'h4);
      chk(16'(clock_divisor), 16'h4);
      w(8'h25, 8'h00);
      w(8'h72, 8'h00);
      {pwr_pin, div_pin} = 4'h5;
      wt(2);
      chk(16'(power_mode[0]), 16'h2);
      chk(16'(power_mode[1]), 16'h2);
      chk(16'(clock_divisor), 16'h2);
      {pwr_pin, div_pin} = 4'h0;
   endtask

   task automatic t_soft();
      w(8'h25, 8'h02);
      w(8'h72, 8'h04);
      w(8'h73, 8'h82);
      w(8'h74, 8'h50);
      wt(2);
      chk(16'(format), 16'h8B);
      soft_reset = 1'b1;
      wt(1);
      soft_reset = 1'b0;
      wt(2);
      chk(16'(format), 16'h88);
      chk(16'(power_mode[0]), 16'h2);
      chk(16'(clock_divisor), 16'h4);
      rdc(8'h73, 8'h82);
   endtask

   task automatic t_slip();
      slips = 0;
      u_acrb_host.slip();
      w(8'h71, 8'h01);
      wt(2);
      chk(16'(slips), 16'h1);
   endtask

   task automatic t_test();
      logic [15:0] a, b;
      logic [3:0]  code [3] = '{4'h1, 4'h2, 4'h3};
      logic [15:0] word [3] = '{16'h8000, 16'hFFFF, 16'h0};
      for (int i = 0; i < 3; i++) begin
         w(8'hC0, {code[i], 4'h0});
         wt(4);
         chk(test_word, word[i]);
      end
      w(8'hC1, 8'h34);
      w(8'hC2, 8'h12);
      w(8'hC3, 8'h78);
      w(8'hC4, 8'h56);
      w(8'hC0, 8'h81);
      wt(4);
      a = test_word;
      wt(1);
      b = test_word;
      chk(16'((a === 16'h1234 && b === 16'h5678) || (a === 16'h5678 && b === 16'h1234)),
          16'h1);
      w(8'hC0, 8'hA0);
      wt(4);
      a = test_word;
      wt(1);
      chk(test_word, a + 16'h1);
      w(8'hC0, 8'h40);
      wt(4);
      a = test_word;
      wt(1);
      chk(16'(a inside {16'h0, 16'hFFFF} && a !== test_word), 16'h1);
      w(8'hC0, 8'h50);
      wt(4);
      chk(16'(test_active), 16'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (clock_slip === 1'b1) slips++;
      if (cycles == 3000) begin
         err_total++;
         results();
      end
   end

   initial begin
      rstn = 1'b0;
      soft_reset = 1'b0;
      cal_done = 1'b0;
      pwr_pin = 2'b00;
      div_pin = 2'b00;
      core_index = 2'b01;
      cal_trim[0] = '{8'h11, 8'h22, 8'h0C, 8'h91, 8'h7E};
      cal_trim[1] = '{8'h33, 8'h44, 8'h03, 8'hA5, 8'h5A};
      wt(2);
      rstn = 1'b1;
      t_cal();
      t_trim();
      t_coarse();
      t_modes();
      t_soft();
      t_slip();
      t_test();
      results();
   end
endmodule

`default_nettype wire
